// File: pkg/cta_pkg.sv
// Constants, types and functions for the clamp timing and auxiliary pin block
package cta_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_PLL_MISC    = 8'h13;
  localparam logic [7:0] IDX_START_HIGH  = 8'h14;
  localparam logic [7:0] IDX_START_LOW   = 8'h15;
  localparam logic [7:0] IDX_CLAMP_WIDTH = 8'h16;
  localparam logic [7:0] IDX_BLC_CONFIG  = 8'h17;
  localparam logic [7:0] IDX_CTRL_STAT   = 8'h20;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_PLL_MISC    = 8'h04;
  localparam logic [7:0] RST_START_HIGH  = 8'h00;
  localparam logic [7:0] RST_START_LOW   = 8'h03;
  localparam logic [7:0] RST_CLAMP_WIDTH = 8'h10;
  localparam logic [7:0] RST_BLC_CONFIG  = 8'h40;
  localparam logic [7:0] RST_CTRL        = 8'h01;

  // ==========================================================================
  // Field positions
  localparam int unsigned POS_LOCK_LEAD  = 0;
  localparam int unsigned POS_AUX_DIS    = 3;
  localparam int unsigned POS_AUX_FN     = 4;
  localparam int unsigned POS_BLC_DIS    = 0;
  localparam int unsigned POS_DC_EN      = 0;
  localparam int unsigned POS_ST_CLAMP   = 4;
  localparam int unsigned POS_ST_PEND    = 5;
  localparam int unsigned POS_ST_AUX     = 6;
  localparam int unsigned POS_ST_HSYNC   = 7;
  localparam int unsigned START_HIGH_W   = 5;
  localparam logic [7:0]  MIN_WIDTH      = 8'h02;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned UPD_DELAY_MS   = 100;
  localparam int unsigned UPD_DELAY_CYC  = UPD_DELAY_MS * 1000 * CLK_MHZ;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CTA_AUX_SAMPLE_CLOCK_INVERT,
    CTA_AUX_CLAMP,
    CTA_AUX_COAST,
    CTA_AUX_EXTERNAL_PIXEL_CLOCK
  } cta_aux_fn_t;

  typedef struct packed {
    logic        lock_lead;
    logic        aux_dis;
    cta_aux_fn_t aux_fn;
    logic [12:0] start;
    logic [7:0]  width;
    logic        dc_en;
    logic        blc_dis;
  } cta_cfg_t;

  typedef struct packed {
    logic pll_lock;
    logic clamp;
    logic blc_start;
    logic dac_update;
    logic clock_invert;
    logic coast_req;
  } cta_evt_t;

  // Byte address of a register index
  function automatic logic [11:0] cta_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

endpackage

// File: rtl/cta_core.sv
// Clamp timing, sync lock edge and auxiliary pin logic with APB registers
//
// Decided for this implementation: register access over APB.
module cta_core #(
  parameter int unsigned UPD_DELAY_CYC = cta_pkg::UPD_DELAY_CYC,
  parameter int unsigned CNT_W         = 13
) (
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [11:0]   paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic      [31:0]   prdata_o,
  output logic               pready_o,
  output logic               pslverr_o,
  input  wire logic          hsync_i,
  input  wire logic          pix_en_i,
  input  wire logic          aux_function_input_pin_i,
  input  wire logic          gain_offset_wr_i,
  output cta_pkg::cta_evt_t  evt_o
);

  // ==========================================================================
  // Parameter checks
  initial begin
    if (CNT_W != 13) begin
      $error("CNT_W must be 13");
    end
    if (UPD_DELAY_CYC < 2) begin
      $error("UPD_DELAY_CYC must be at least 2");
    end
  end

  // ==========================================================================
  // Registers
  logic [7:0]        misc_r;
  logic [7:0]        start_hi_r;
  logic [7:0]        start_lo_r;
  logic [7:0]        width_r;
  logic [7:0]        blc_r;
  logic [7:0]        ctrl_r;
  logic [31:0]       prdata_r;
  cta_pkg::cta_cfg_t cfg;

  function automatic logic is_mapped(input logic [11:0] a);
    return a == cta_pkg::cta_addr(cta_pkg::IDX_PLL_MISC)
        || a == cta_pkg::cta_addr(cta_pkg::IDX_START_HIGH)
        || a == cta_pkg::cta_addr(cta_pkg::IDX_START_LOW)
        || a == cta_pkg::cta_addr(cta_pkg::IDX_CLAMP_WIDTH)
        || a == cta_pkg::cta_addr(cta_pkg::IDX_BLC_CONFIG)
        || a == cta_pkg::cta_addr(cta_pkg::IDX_CTRL_STAT);
  endfunction

  function automatic logic role_is(input cta_pkg::cta_aux_fn_t fn,
                                   input cta_pkg::cta_aux_fn_t want);
    return fn == want;
  endfunction

  logic wr_en;
  logic setup;
  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pwrite_i && is_mapped(paddr_i);

  // No wait states: read data is captured in the setup cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !is_mapped(paddr_i);
  assign prdata_o  = prdata_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      misc_r     <= cta_pkg::RST_PLL_MISC;
      start_hi_r <= cta_pkg::RST_START_HIGH;
      start_lo_r <= cta_pkg::RST_START_LOW;
      width_r    <= cta_pkg::RST_CLAMP_WIDTH;
      blc_r      <= cta_pkg::RST_BLC_CONFIG;
      ctrl_r     <= cta_pkg::RST_CTRL;
    end else if (wr_en) begin
      case (paddr_i)
        cta_pkg::cta_addr(cta_pkg::IDX_PLL_MISC):    misc_r <= pwdata_i[7:0];
        cta_pkg::cta_addr(cta_pkg::IDX_START_HIGH): begin
          start_hi_r <= {3'h0, pwdata_i[cta_pkg::START_HIGH_W-1:0]};
        end
        cta_pkg::cta_addr(cta_pkg::IDX_START_LOW):   start_lo_r <= pwdata_i[7:0];
        cta_pkg::cta_addr(cta_pkg::IDX_CLAMP_WIDTH): width_r    <= pwdata_i[7:0];
        cta_pkg::cta_addr(cta_pkg::IDX_BLC_CONFIG):  blc_r      <= pwdata_i[7:0];
        cta_pkg::cta_addr(cta_pkg::IDX_CTRL_STAT):   ctrl_r     <= {7'h00, pwdata_i[0]};
        default: begin
        end
      endcase
    end
  end

  // Decoded configuration
  always_comb begin
    cfg.lock_lead = misc_r[cta_pkg::POS_LOCK_LEAD];
    cfg.aux_dis   = misc_r[cta_pkg::POS_AUX_DIS];
    cfg.aux_fn    = cta_pkg::cta_aux_fn_t'(misc_r[cta_pkg::POS_AUX_FN +: 2]);
    cfg.start     = {start_hi_r[cta_pkg::START_HIGH_W-1:0], start_lo_r};
    cfg.width     = width_r;
    cfg.dc_en     = ctrl_r[cta_pkg::POS_DC_EN];
    cfg.blc_dis   = blc_r[cta_pkg::POS_BLC_DIS];
  end

  // ==========================================================================
  // Input edges
  logic hs_q_r;
  logic aux_q_r;
  logic aux_eff;
  logic hs_rise;
  logic hs_fall;
  logic aux_rise;
  logic ext_clamp;
  logic ext_pix;
  logic pix_stb;

  assign aux_eff   = cfg.aux_dis ? 1'b0 : aux_function_input_pin_i;
  assign hs_rise   = hsync_i && !hs_q_r;
  assign hs_fall   = !hsync_i && hs_q_r;
  assign aux_rise  = aux_eff && !aux_q_r;
  assign ext_clamp = role_is(cfg.aux_fn, cta_pkg::CTA_AUX_CLAMP);
  assign ext_pix   = role_is(cfg.aux_fn, cta_pkg::CTA_AUX_EXTERNAL_PIXEL_CLOCK);
  // In pixel clock role each rising edge of the pin counts one pixel
  assign pix_stb   = ext_pix ? aux_rise : pix_en_i;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hs_q_r  <= 1'b0;
      aux_q_r <= 1'b0;
    end else begin
      hs_q_r  <= hsync_i;
      aux_q_r <= aux_eff;
    end
  end

  // ==========================================================================
  // Pixel counter from sync trailing edge
  logic [CNT_W-1:0] pix_cnt_r;
  logic             armed_r;
  logic             hit;
  logic             wide_ok;

  assign hit     = armed_r && pix_stb && !hs_fall && pix_cnt_r == cfg.start;
  assign wide_ok = cfg.width >= cta_pkg::MIN_WIDTH;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pix_cnt_r <= '0;
      armed_r   <= 1'b0;
    end else if (hs_fall) begin
      pix_cnt_r <= '0;
      armed_r   <= 1'b1;
    end else if (hit) begin
      armed_r   <= 1'b0;
    end else if (pix_stb && armed_r) begin
      pix_cnt_r <= pix_cnt_r + 1'b1;
    end
  end

  // ==========================================================================
  // Internal clamp pulse, width counted in pixels
  logic [7:0] wid_cnt_r;
  logic       int_clamp_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wid_cnt_r   <= '0;
      int_clamp_r <= 1'b0;
    end else if (ext_clamp) begin
      int_clamp_r <= 1'b0;
    end else if (hit && wide_ok) begin
      wid_cnt_r   <= cfg.width;
      int_clamp_r <= 1'b1;
    end else if (int_clamp_r && pix_stb) begin
      wid_cnt_r <= wid_cnt_r - 8'h01;
      if (wid_cnt_r == 8'h01) begin
        int_clamp_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Offset DAC update and fallback timer
  logic        clamp_evt;
  logic        tmo_hit;
  logic        pend_r;
  logic [31:0] tmo_cnt_r;

  // Clamp leading edge, internal or external, always loads the DACs
  assign clamp_evt = ext_clamp ? aux_rise : (hit && wide_ok);
  // Fallback only when no internal clamp fires; never in external mode
  assign tmo_hit   = !ext_clamp && pend_r && tmo_cnt_r == UPD_DELAY_CYC - 1;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_r <= 1'b0;
    end else begin
      // A write in the update cycle stays pending
      pend_r <= gain_offset_wr_i || (pend_r && !(clamp_evt || tmo_hit));
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tmo_cnt_r <= '0;
    end else if (!pend_r || ext_clamp || clamp_evt || tmo_hit) begin
      tmo_cnt_r <= '0;
    end else begin
      tmo_cnt_r <= tmo_cnt_r + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      evt_o <= '0;
    end else begin
      evt_o.pll_lock     <= cfg.lock_lead ? hs_rise : hs_fall;
      evt_o.clamp        <= cfg.dc_en && (ext_clamp ? aux_eff : int_clamp_r);
      evt_o.blc_start    <= !cfg.blc_dis && (ext_clamp ? aux_rise : hit);
      evt_o.dac_update   <= clamp_evt || tmo_hit;
      evt_o.clock_invert <= role_is(cfg.aux_fn, cta_pkg::CTA_AUX_SAMPLE_CLOCK_INVERT) && aux_eff;
      evt_o.coast_req    <= role_is(cfg.aux_fn, cta_pkg::CTA_AUX_COAST) && aux_eff;
    end
  end

  // ==========================================================================
  // Read data
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_r <= '0;
    end else if (setup && !pwrite_i) begin
      case (paddr_i)
        cta_pkg::cta_addr(cta_pkg::IDX_PLL_MISC):    prdata_r <= {24'h0, misc_r};
        cta_pkg::cta_addr(cta_pkg::IDX_START_HIGH):  prdata_r <= {24'h0, start_hi_r};
        cta_pkg::cta_addr(cta_pkg::IDX_START_LOW):   prdata_r <= {24'h0, start_lo_r};
        cta_pkg::cta_addr(cta_pkg::IDX_CLAMP_WIDTH): prdata_r <= {24'h0, width_r};
        cta_pkg::cta_addr(cta_pkg::IDX_BLC_CONFIG):  prdata_r <= {24'h0, blc_r};
        cta_pkg::cta_addr(cta_pkg::IDX_CTRL_STAT): begin
          prdata_r <= {24'h0, hs_q_r, aux_q_r, pend_r, evt_o.clamp, 3'h0, ctrl_r[0]};
        end
        default: prdata_r <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  a_lock_trail_edge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (hs_fall && !cfg.lock_lead) |=> evt_o.pll_lock)
    else $error("lock pulse missing on trailing edge");

  a_lock_lead_edge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    evt_o.pll_lock |-> $past(cfg.lock_lead) ? $past(hs_rise) : $past(hs_fall))
    else $error("lock pulse on wrong edge");

  a_aux_pin_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $past(cfg.aux_dis) |-> !evt_o.clock_invert && !evt_o.coast_req)
    else $error("disabled aux pin still acts");

  a_ext_dac_edge: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (evt_o.dac_update && $past(ext_clamp)) |-> $past(aux_rise))
    else $error("dac update without external clamp edge");

  a_int_clamp_gen: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (hit && wide_ok && !ext_clamp) |=> int_clamp_r ##0 evt_o.dac_update)
    else $error("internal clamp not generated");

  a_width_min: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(int_clamp_r) |-> $past(cfg.width) >= cta_pkg::MIN_WIDTH ##1 int_clamp_r)
    else $error("clamp pulse with width below minimum");

  a_cnt_restart: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    hs_fall |=> pix_cnt_r == '0 && armed_r)
    else $error("pixel counter not restarted at trailing edge");

  a_blc_gate_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    evt_o.blc_start |-> !$past(cfg.blc_dis))
    else $error("black-level start while disabled");

  a_blc_no_width: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (hit && !ext_clamp && !cfg.blc_dis) |=> evt_o.blc_start)
    else $error("black-level start depends on clamp width");

  a_upd_bound: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tmo_cnt_r < UPD_DELAY_CYC)
    else $error("pending update waited past its limit");

  a_pend_clears: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (pend_r && clamp_evt && !gain_offset_wr_i) |=> !pend_r && evt_o.dac_update)
    else $error("clamp did not transfer pending values");

  a_aux_pin_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cfg.aux_dis |=> !aux_q_r)
    else $error("disabled aux pin not held low");

  a_role_invert: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (role_is(cfg.aux_fn, cta_pkg::CTA_AUX_SAMPLE_CLOCK_INVERT) && aux_eff) |=> evt_o.clock_invert)
    else $error("clock invert role not followed");

  a_role_coast: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (role_is(cfg.aux_fn, cta_pkg::CTA_AUX_COAST) && aux_eff) |=> evt_o.coast_req)
    else $error("coast role not followed");

  a_pix_role_cnt: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ext_pix && !aux_rise && !hs_fall) |=> $stable(pix_cnt_r))
    else $error("pixel counted without pin edge");

  a_ext_no_int: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ext_clamp |=> !int_clamp_r)
    else $error("internal clamp in external clamp role");

  a_ext_clamp_lvl: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ext_clamp && cfg.dc_en) |=> evt_o.clamp == $past(aux_eff))
    else $error("restore clamp does not follow external pulse");

  a_restore_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !cfg.dc_en |=> !evt_o.clamp)
    else $error("restore clamp while restore disabled");

  a_ext_blc_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ext_clamp && aux_rise && !cfg.blc_dis) |=> evt_o.blc_start)
    else $error("external clamp did not start black level");

  a_narrow_none: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (hit && !wide_ok && !int_clamp_r) |=> !int_clamp_r)
    else $error("clamp pulse from a width below minimum");

  a_width_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (hit && wide_ok && !ext_clamp) |=> wid_cnt_r == $past(cfg.width))
    else $error("clamp width not loaded at start");

  a_clamp_end: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (int_clamp_r && pix_stb && wid_cnt_r == 8'h01 && !hit) |=> !int_clamp_r)
    else $error("clamp pulse longer than its width");

  a_cnt_frozen: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!armed_r && !hs_fall) |=> $stable(pix_cnt_r))
    else $error("pixel counter moved after its hit");

  a_cnt_step: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (armed_r && pix_stb && !hs_fall && !hit) |=> pix_cnt_r == $past(pix_cnt_r) + 1'b1)
    else $error("pixel counter missed a strobe");

  a_pend_set: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    gain_offset_wr_i |=> pend_r)
    else $error("gain or offset write not made pending");

endmodule

// File: tb/cta_video_src.sv
// Video source model: horizontal sync lines and pixel strobes
module cta_video_src #(
  parameter int LINE = 300,
  parameter int SYNC = 20
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic run_i,
  input  wire logic slow_i,
  output logic      hsync_o,
  output logic      pix_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_r;

  // ==========================================================================
  // Line timing
  // Sync stays low while stopped, so no edge reaches the block between runs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r    <= 0;
      hsync_o  <= 1'h0;
      pix_en_o <= 1'h0;
    end else begin
      cnt_r    <= (cnt_r == LINE - 1) ? 0 : cnt_r + 1;
      hsync_o  <= run_i && (cnt_r < SYNC);
      pix_en_o <= slow_i ? ~pix_en_o : 1'h1;
    end
  end
endmodule

// File: tb/cta_core_bench.sv
// Self-checking bench for the clamp timing and auxiliary pin block
module cta_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LINE = 300;
  localparam int SYNC = 20;
  localparam int UPD  = 20;
  logic              clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr;
  logic              hsync, pix_en, aux_pin, go_wr, run, slow, er;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic [7:0]        rd;
  cta_pkg::cta_evt_t evt;
  int                mismatches, compares, t, n_clamp, n_blc, n_dac, t_blc, t_lock;

  cta_core #(.UPD_DELAY_CYC(UPD)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .hsync_i(hsync),
    .pix_en_i(pix_en), .aux_function_input_pin_i(aux_pin), .gain_offset_wr_i(go_wr),
    .evt_o(evt));
  cta_video_src #(.LINE(LINE), .SYNC(SYNC)) src (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .run_i(run), .slow_i(slow), .hsync_o(hsync), .pix_en_o(pix_en));

  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Event monitor, counts are zeroed at the start of each window
  always @(posedge clk_i) begin
    t++;
    if (evt.clamp === 1'h1) n_clamp++;
    if (evt.dac_update === 1'h1) n_dac++;
    if (evt.blc_start === 1'h1) begin
      n_blc++;
      if (t_blc < 0) t_blc = t;
    end
    if (evt.pll_lock === 1'h1 && t_lock < 0) t_lock = t;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_i);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h000000, d};
    @(posedge clk_i);
    penable <= 1'h1;
    // Waits as long as the slave stalls; only the watchdog ends a hung transfer
    do begin
      @(posedge clk_i);
    end while (pready !== 1'h1);
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  function automatic logic [7:0] misc(input logic [1:0] role, input logic dis, input logic lk);
    return 8'h04 | {2'h0, role, dis, 2'h0, lk};
  endfunction

  // Window opens at a sync trailing edge; the monitor already ran at that edge
  task automatic begin_win();
    @(negedge hsync);
    t = 0; n_clamp = 0; n_blc = 0; n_dac = 0; t_blc = -1; t_lock = -1;
  endtask

  task automatic end_win();
    while (t < LINE - 1) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic measure();
    begin_win();
    end_win();
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] idx[4];
    logic [7:0] rst[4];
    idx = '{8'h13, 8'h14, 8'h15, 8'h16};
    rst = '{8'h04, 8'h00, 8'h03, 8'h10};
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, idx[i], 8'h00);
      check(rd, rst[i], "reset value");
    end
    apb(1'h1, 8'h16, 8'h5A);
    apb(1'h0, 8'h16, 8'h00);
    check({rd, er}, {8'h5A, 1'h0}, "width readback");
    apb(1'h1, 8'h30, 8'hFF);
    check(er, 1'h1, "unmapped write");
    apb(1'h0, 8'h30, 8'h00);
    check({rd, er}, {8'h00, 1'h1}, "unmapped read");
    apb(1'h1, 8'h16, 8'h10);
  endtask

  task automatic t_lock_edge();
    for (int lk = 0; lk < 2; lk++) begin
      apb(1'h1, 8'h13, misc(2'h0, 1'h0, lk[0]));
      measure();
      check(lk ? (t_lock >= LINE - SYNC && t_lock <= LINE - SYNC + 4)
               : (t_lock > 0 && t_lock <= 4), 1, "lock edge");
    end
    apb(1'h1, 8'h13, misc(2'h0, 1'h0, 1'h0));
  endtask

  task automatic t_width();
    logic [7:0] w[4];
    w = '{8'h10, 8'h02, 8'h01, 8'h00};
    foreach (w[i]) begin
      apb(1'h1, 8'h16, w[i]);
      measure();
      check(n_clamp, (w[i] >= 8'h02) ? w[i] : 0, "clamp width");
      check(n_blc, 1, "black start with any width");
      check(n_dac, (w[i] >= 8'h02) ? 1 : 0, "dac load");
    end
    apb(1'h1, 8'h16, 8'h04);
    slow <= 1'h1;
    measure();
    check(n_clamp, 8, "width counted in pixels");
    slow <= 1'h0;
    apb(1'h1, 8'h20, 8'h00);
    measure();
    check({n_clamp[7:0], n_dac[7:0]}, 16'h0001, "restore off, dac still");
    apb(1'h1, 8'h20, 8'h01);
    apb(1'h1, 8'h17, 8'h41);
    measure();
    check(n_blc, 0, "black-level disabled");
    apb(1'h1, 8'h17, 8'h40);
    apb(1'h1, 8'h16, 8'h10);
  endtask

  task automatic t_start();
    int t0;
    measure();
    t0 = t_blc;
    apb(1'h1, 8'h14, 8'h01);
    apb(1'h1, 8'h15, 8'h02);
    measure();
    check(t_blc - t0, 255, "13-bit start position");
    check(n_blc, 1, "one hit per line");
    apb(1'h1, 8'h14, 8'h00);
    apb(1'h1, 8'h15, 8'h03);
  endtask

  task automatic t_aux();
    aux_pin <= 1'h1;
    for (int r = 0; r < 3; r += 2) begin
      apb(1'h1, 8'h13, misc(r[1:0], 1'h0, 1'h0));
      repeat (4) @(posedge clk_i);
      check({evt.clock_invert, evt.coast_req}, {r == 0, r == 2}, "pin role");
    end
    apb(1'h1, 8'h13, misc(2'h2, 1'h1, 1'h0));
    repeat (4) @(posedge clk_i);
    check(evt.coast_req, 1'h0, "pin disabled");
    aux_pin <= 1'h0;
    apb(1'h1, 8'h13, misc(2'h1, 1'h0, 1'h0));
    measure();
    check({n_clamp[7:0], n_dac[7:0]}, 16'h0000, "no internal clamp");
    begin_win();
    repeat (50) @(posedge clk_i);
    aux_pin <= 1'h1;
    repeat (3) @(posedge clk_i);
    aux_pin <= 1'h0;
    end_win();
    check(n_dac, 1, "load on pin leading edge");
    check({n_clamp[7:0], n_blc[7:0]}, 16'h0301, "external clamp pulse");
    apb(1'h1, 8'h13, misc(2'h3, 1'h0, 1'h0));
    measure();
    check(n_blc, 0, "pin is the pixel clock");
    begin_win();
    repeat (4) begin
      @(posedge clk_i);
      aux_pin <= 1'h1;
      @(posedge clk_i);
      aux_pin <= 1'h0;
    end
    end_win();
    // Start is 3, so the fourth pin edge after the trailing edge is the hit
    check({n_blc[7:0], n_dac[7:0]}, 16'h0101, "pin edges count pixels");
    apb(1'h1, 8'h13, misc(2'h0, 1'h0, 1'h0));
  endtask

  // Must run last: it leaves an update pending in the external clamp role
  task automatic t_fallback();
    int n;
    run <= 1'h0;
    repeat (LINE) @(posedge clk_i);
    go_wr <= 1'h1;
    @(posedge clk_i);
    go_wr <= 1'h0;
    n = 0;
    while (evt.dac_update !== 1'h1 && n < UPD + 10) begin
      @(negedge clk_i);
      n++;
    end
    check(n > 0 && n <= UPD + 4, 1, "delayed update without clamp");
    apb(1'h1, 8'h13, misc(2'h1, 1'h0, 1'h0));
    go_wr <= 1'h1;
    @(posedge clk_i);
    go_wr <= 1'h0;
    @(negedge clk_i);
    n_dac = 0;
    repeat (3 * UPD) @(posedge clk_i);
    @(negedge clk_i);
    check(n_dac, 0, "no timed update in external role");
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h000; pwdata = 32'h0;
    aux_pin = 1'h0; go_wr = 1'h0; run = 1'h1; slow = 1'h0; arst_n_i = 1'h0;
    repeat (20) @(posedge clk_i);
    arst_n_i <= 1'h1;
    t_regs();
    t_lock_edge();
    t_width();
    t_start();
    t_aux();
    t_fallback();
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end
endmodule
